// *** hdl/tw_fifo.sv ***
// Shared constants for the serial register loader and its word FIFO.
`timescale 1ns/1ps
package tw_pkg;
	localparam int TW_WORD_W = 24;
	localparam int TW_SEL_W = 4;
	localparam int TW_NREG = 16;
	localparam int TW_FIFO_D = 8;
	localparam int TW_PWR_LSB = 4;
	localparam int TW_PWR_W = 4;
	localparam logic [3:0] TW_REG_ZERO = 4'h0;
	localparam logic [3:0] TW_PWR_IDX = 4'h1;
	localparam logic [3:0] TW_PWR_OFF = 4'h0;
endpackage

////////////////////////////////////////////////////////////////////////////////
module tw_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
)
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [WIDTH-1:0] mem_nxt [DEPTH];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop;

	// The count is one bit wider than the pointers so that a full FIFO is not read as empty.
	assign in_ready = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data = mem_r[rp_r];

	always_comb
	begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		mem_nxt = mem_r;
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		cnt_nxt = cnt_r;
		if (push)
		begin
			mem_nxt[wp_r] = in_data;
			wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
		end
		if (pop)
			rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
		if (push && !pop)
			cnt_nxt = cnt_r + (AW+1)'(1);
		else if (pop && !push)
			cnt_nxt = cnt_r - (AW+1)'(1);
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem_r[i] <= '0;
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			mem_r <= mem_nxt;
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	fifo_bound_a: assert property (@(posedge clk) disable iff (!arst_n)
		cnt_r <= (AW+1)'(DEPTH))
		else $error("FIFO count out of bounds.");

	fifo_count_a: assert property (@(posedge clk) disable iff (!arst_n)
		push && !pop |=> cnt_r == $past(cnt_r) + (AW+1)'(1))
		else $error("FIFO count not advancing on push.");
endmodule

// *** hdl/tw_loader.sv ***
// Three-wire serial programming port: shift register, load strobe, register file, power gate.
//
// Behaviour
// - Each serial clock rising edge shifts the data line into the shift register.
// - Words arrive most significant bit first; first bit received ends up on top.
// - The trailing bits shifted in select the destination register.
// - Strobe rising edge stages the shift register for the FIFO, which drains into the selected register.
// - Chip enable high powers only the sections enabled by stored power bits.
// - Serial writes are accepted and kept while chip enable is low.
`timescale 1ns/1ps
module tw_loader
	import tw_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic latch_load_strobe,
	input wire logic chip_en,
	input wire logic drain_hold,
	input wire logic [TW_SEL_W-1:0] rd_idx,
	output logic [TW_WORD_W-1:0] rd_data_r,
	output logic [TW_PWR_W-1:0] section_en_r,
	output logic relock_r,
	output logic lock_armed_r,
	output logic load_pend_r
);
	////////////////////////////////////////////////////////////////////////////
	function automatic logic [TW_SEL_W-1:0] sel_of(input logic [TW_WORD_W-1:0] w);
		sel_of = w[TW_SEL_W-1:0];
	endfunction

	function automatic logic [TW_PWR_W-1:0] pwr_of(input logic [TW_WORD_W-1:0] w);
		pwr_of = w[TW_PWR_LSB +: TW_PWR_W];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; the third clock and strobe stages only feed edge detection.
	logic clk_s1, clk_s2, clk_s3;
	logic dat_s1, dat_s2;
	logic stb_s1, stb_s2, stb_s3;
	logic ce_s1, ce_s2;
	logic clk_rise, stb_rise;

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			clk_s1 <= 1'b0;
			clk_s2 <= 1'b0;
			clk_s3 <= 1'b0;
			dat_s1 <= 1'b0;
			dat_s2 <= 1'b0;
			stb_s1 <= 1'b0;
			stb_s2 <= 1'b0;
			stb_s3 <= 1'b0;
			ce_s1 <= 1'b0;
			ce_s2 <= 1'b0;
		end
		else
		begin
			clk_s1 <= ser_clk;
			clk_s2 <= clk_s1;
			clk_s3 <= clk_s2;
			dat_s1 <= ser_data;
			dat_s2 <= dat_s1;
			stb_s1 <= latch_load_strobe;
			stb_s2 <= stb_s1;
			stb_s3 <= stb_s2;
			ce_s1 <= chip_en;
			ce_s2 <= ce_s1;
		end
	end

	assign clk_rise = clk_s2 && !clk_s3;
	assign stb_rise = stb_s2 && !stb_s3;

	////////////////////////////////////////////////////////////////////////////
	// Shift register and the word waiting to enter the FIFO.
	logic [TW_WORD_W-1:0] shift_r, shift_nxt;
	logic [TW_WORD_W-1:0] pend_word_r, pend_word_nxt;
	logic load_pend_nxt;
	logic f_in_ready, f_out_valid, f_out_ready;
	logic [TW_WORD_W-1:0] f_out_data;

	always_comb
	begin
		shift_nxt = shift_r;
		pend_word_nxt = pend_word_r;
		load_pend_nxt = load_pend_r;
		if (clk_rise)
			shift_nxt = {shift_r[TW_WORD_W-2:0], dat_s2};
		if (load_pend_r && f_in_ready)
			load_pend_nxt = 1'b0;
		// A new strobe while a word still waits for room replaces that word.
		if (stb_rise)
		begin
			load_pend_nxt = 1'b1;
			pend_word_nxt = shift_r;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			shift_r <= '0;
			pend_word_r <= '0;
			load_pend_r <= 1'b0;
		end
		else
		begin
			shift_r <= shift_nxt;
			pend_word_r <= pend_word_nxt;
			load_pend_r <= load_pend_nxt;
		end
	end

	tw_fifo #(
		.WIDTH(TW_WORD_W),
		.DEPTH(TW_FIFO_D)
	) u_fifo (
		.clk(core_clk),
		.arst_n(arst_n),
		.in_valid(load_pend_r),
		.in_ready(f_in_ready),
		.in_data(pend_word_r),
		.out_valid(f_out_valid),
		.out_ready(f_out_ready),
		.out_data(f_out_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// Register file, power gate and relock tracking.
	logic [TW_WORD_W-1:0] regs_r [TW_NREG];
	logic [TW_WORD_W-1:0] regs_nxt [TW_NREG];
	logic [TW_WORD_W-1:0] rd_data_nxt;
	logic [TW_PWR_W-1:0] section_en_nxt;
	logic relock_nxt, lock_armed_nxt, fire;

	assign f_out_ready = !drain_hold;
	assign fire = f_out_valid && f_out_ready;

	always_comb
	begin
		regs_nxt = regs_r;
		relock_nxt = 1'b0;
		// Writes land regardless of chip enable.
		if (fire)
		begin
			regs_nxt[sel_of(f_out_data)] = f_out_data;
			relock_nxt = (sel_of(f_out_data) == TW_REG_ZERO);
		end
		section_en_nxt = ce_s2 ? pwr_of(regs_r[TW_PWR_IDX]) : TW_PWR_OFF;
		// Relock is armed only by a register zero write made while powered up.
		if (!ce_s2)
			lock_armed_nxt = 1'b0;
		else if (relock_nxt)
			lock_armed_nxt = 1'b1;
		else
			lock_armed_nxt = lock_armed_r;
		rd_data_nxt = regs_r[rd_idx];
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int i = 0; i < TW_NREG; i++)
				regs_r[i] <= '0;
			rd_data_r <= '0;
			section_en_r <= TW_PWR_OFF;
			relock_r <= 1'b0;
			lock_armed_r <= 1'b0;
		end
		else
		begin
			regs_r <= regs_nxt;
			rd_data_r <= rd_data_nxt;
			section_en_r <= section_en_nxt;
			relock_r <= relock_nxt;
			lock_armed_r <= lock_armed_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	sequence seq_strobe;
		stb_rise;
	endsequence

	sequence seq_staged;
		load_pend_r && pend_word_r == $past(shift_r);
	endsequence

	shift_in_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		clk_rise |=> shift_r == {$past(shift_r[TW_WORD_W-2:0]), $past(dat_s2)})
		else $error("Shift register did not take the data bit on a clock rise.");

	msb_first_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		clk_rise |=> shift_r[TW_WORD_W-1] == $past(shift_r[TW_WORD_W-2]))
		else $error("First received bit is not moving toward the top.");

	shift_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		!clk_rise |=> $stable(shift_r))
		else $error("Shift register moved without a serial clock rise.");

	strobe_load_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		seq_strobe |=> seq_staged)
		else $error("Strobe rise did not stage the shift register contents.");

	sel_decode_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		fire |=> regs_r[$past(f_out_data[TW_SEL_W-1:0])] == $past(f_out_data))
		else $error("Word not stored in the register chosen by its trailing bits.");

	power_gate_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		##1 section_en_r == ($past(ce_s2) ? $past(regs_r[TW_PWR_IDX][TW_PWR_LSB +: TW_PWR_W])
			: TW_PWR_OFF))
		else $error("Enabled sections do not follow chip enable and power bits.");

	down_write_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		fire && !ce_s2 |=> regs_r[$past(f_out_data[TW_SEL_W-1:0])] == $past(f_out_data)
			##1 ($past(fire)
			&& $past(f_out_data[TW_SEL_W-1:0]) == $past(f_out_data[TW_SEL_W-1:0], 2))
			|| regs_r[$past(f_out_data[TW_SEL_W-1:0], 2)] == $past(f_out_data, 2))
		else $error("Write while powered down was lost.");

	relock_pulse_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		fire && sel_of(f_out_data) == TW_REG_ZERO |=> relock_r ##1
			relock_r == ($past(fire) && $past(f_out_data[TW_SEL_W-1:0]) == TW_REG_ZERO))
		else $error("Register zero write did not give one relock pulse.");

	armed_clear_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		!ce_s2 |=> !lock_armed_r)
		else $error("Relock armed while chip enable is low.");
endmodule

// *** testbench/tw_host.sv ***
// Host controller model that shifts words into the three-wire programming port.
`timescale 1ns/1ps
module tw_host
(
	input wire logic clk,
	output logic ser_clk,
	output logic ser_data,
	output logic latch_load_strobe
);
	initial
	begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		latch_load_strobe = 1'b0;
	end
	// Data moves while the link clock is low; the clock stands still between words.
	task automatic send(input logic [23:0] w);
		for (int i = 23; i >= 0; i--)
		begin
			@(negedge clk);
			ser_data = w[i];
			repeat (3) @(negedge clk);
			ser_clk = 1'b1;
			repeat (4) @(negedge clk);
			ser_clk = 1'b0;
		end
		ser_data = ~w[0];
		repeat (4) @(negedge clk);
		latch_load_strobe = 1'b1;
		repeat (4) @(negedge clk);
		latch_load_strobe = 1'b0;
		repeat (4) @(negedge clk);
	endtask
endmodule

// *** testbench/tb_tw_loader.sv ***
// Self-checking bench for the serial register loader.
`timescale 1ns/1ps
module tb_tw_loader
	import tw_pkg::*;
;
	logic core_clk, arst_n, chip_en, drain_hold, go, ser_clk, ser_data, strobe;
	logic relock_r, lock_armed_r, load_pend_r;
	logic [3:0] rd_idx, section_en_r;
	logic [23:0] rd_data_r, w, got;
	logic [23:0] regs [16];
	logic [23:0] fw [9];
	logic [26:0] e;
	logic [26:0] q [$];
	string nm [5] = '{"rd_data", "section_en", "relock_cnt", "lock_armed", "load_pend"};
	int err_count = 0;
	int check_count = 0;
	int relock_cnt = 0;
	int nr = 0;

	tw_host host (.clk(core_clk), .ser_clk(ser_clk), .ser_data(ser_data),
		.latch_load_strobe(strobe));
	tw_loader DUT (.core_clk(core_clk), .arst_n(arst_n), .ser_clk(ser_clk),
		.ser_data(ser_data), .latch_load_strobe(strobe), .chip_en(chip_en),
		.drain_hold(drain_hold), .rd_idx(rd_idx), .rd_data_r(rd_data_r),
		.section_en_r(section_en_r), .relock_r(relock_r), .lock_armed_r(lock_armed_r),
		.load_pend_r(load_pend_r));

	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	always @(posedge core_clk)
	begin
		if (relock_r === 1'b1)
			relock_cnt++;
	end

	////////////////////////////////////////////////////////////////////////////////
	always @(negedge core_clk)
	begin
		if (go === 1'b1)
		begin
			e = q.pop_front();
			case (e[26:24])
				3'h0: got = rd_data_r;
				3'h1: got = 24'(section_en_r);
				3'h2: got = 24'(relock_cnt);
				3'h3: got = 24'(lock_armed_r);
				default: got = 24'(load_pend_r);
			endcase
			check_count++;
			if (got !== e[23:0])
			begin
				$display("unexpected %s expected %h seen %h", nm[e[26:24]], e[23:0], got);
				err_count++;
			end
		end
	end

	task automatic chk(input logic [2:0] s, input logic [23:0] x);
		@(negedge core_clk);
		q.push_back({s, x});
		go <= 1'b1;
		@(negedge core_clk);
		go <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] i);
		@(negedge core_clk);
		rd_idx <= i;
		chk(3'h0, regs[i]);
	endtask

	task automatic put(input logic [23:0] v);
		host.send(v);
		regs[v[3:0]] = v;
		if (v[3:0] == TW_REG_ZERO)
			nr++;
	endtask

	task automatic do_reset();
		@(negedge core_clk);
		arst_n <= 1'b0;
		repeat (2) @(negedge core_clk);
		arst_n <= 1'b1;
		foreach (regs[i])
			regs[i] = 24'h00_0000;
	endtask

	task final_report;
		if (err_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		#400000;
		err_count++;
		final_report;
	end

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		arst_n = 1'b0;
		chip_en = 1'b0;
		drain_hold = 1'b0;
		rd_idx = 4'h0;
		go = 1'b0;
		void'($urandom(53395));
		do_reset();
		chk(3'h1, 24'h00_0000);
		chk(3'h4, 24'h00_0000);
		rd(4'h5);
		// Every register is programmed while the part is powered down.
		for (int i = 0; i < 16; i++)
		begin
			w = $urandom();
			put({w[23:4], i[3:0]});
		end
		for (int i = 0; i < 16; i++)
			rd(i[3:0]);
		chk(3'h1, 24'h00_0000);
		chk(3'h2, 24'(nr));
		chk(3'h3, 24'h00_0000);
		@(negedge core_clk);
		chip_en <= 1'b1;
		repeat (4) @(negedge core_clk);
		chk(3'h1, 24'(regs[TW_PWR_IDX][TW_PWR_LSB +: TW_PWR_W]));
		w = $urandom();
		put({w[23:4], TW_REG_ZERO});
		chk(3'h2, 24'(nr));
		chk(3'h3, 24'h00_0001);
		rd(TW_REG_ZERO);
		// Fill the FIFO while the drain stalls, then let it empty.
		@(negedge core_clk);
		drain_hold <= 1'b1;
		for (int i = 0; i < 9; i++)
		begin
			w = $urandom();
			fw[i] = {w[23:4], 4'(i + 2)};
			host.send(fw[i]);
		end
		chk(3'h4, 24'h00_0001);
		rd(4'h2);
		@(negedge core_clk);
		drain_hold <= 1'b0;
		repeat (20) @(negedge core_clk);
		foreach (fw[i])
			regs[fw[i][3:0]] = fw[i];
		chk(3'h4, 24'h00_0000);
		for (int i = 2; i < 11; i++)
			rd(i[3:0]);
		@(negedge core_clk);
		chip_en <= 1'b0;
		repeat (4) @(negedge core_clk);
		chk(3'h3, 24'h00_0000);
		chk(3'h1, 24'h00_0000);
		chip_en <= 1'b1;
		do_reset();
		rd(TW_PWR_IDX);
		chk(3'h1, 24'h00_0000);
		final_report;
	end
endmodule
